/* verilog/flash_front_end_regs.vh */
// Purpose: Constants of the serial flash command front end.
// Assumes: Included by the command front end module by bare name.
// Notes:   Definitions only.
`ifndef FLASH_FRONT_END_REGS_VH
`define FLASH_FRONT_END_REGS_VH
// ==========================================================================
// Opcodes
`define OP_READ_LEGACY     8'hE8
`define OP_READ_FAST       8'h1B
`define OP_QUAD_ENABLE     8'h3D
`define OP_READ_DUAL       8'h3B
`define OP_READ_QUAD       8'h6B
`define OP_WRITE_DUAL      8'h24
`define OP_WRITE_QUAD      8'h44
// ==========================================================================
// Framing counts
`define OPCODE_BITS        8
`define ADDR_BITS          24
`define DUMMY_LEGACY_BYTES 4
`define DUMMY_FAST_BYTES   2
`define DUMMY_WIDE_BYTES   1
// ==========================================================================
// Address layout
`define PAGE_BITS          12
`define OFS_BITS_STD       10
`define OFS_BITS_BIN       9
`define PAGE_LAST_STD      10'h20F
`define PAGE_LAST_BIN      10'h1FF
`define PAGE_LAST_ROW      12'hFFF
`endif

/* verilog/stream_fifo.v */
// Purpose: Small synchronous FIFO with valid and ready on both sides.
// Assumes: One clock; depth is a power of two.
// Notes:   Full and empty come from an occupancy count.
`timescale 1ns/1ps
`default_nettype none
module stream_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             clk,       // system clock
  input  wire             resetn,    // async reset, active low
  input  wire             flush,     // drop all contents
  input  wire             in_valid,  // write request
  output wire             in_ready,  // space available
  input  wire [WIDTH-1:0] in_data,   // write data
  output wire             out_valid, // data available
  input  wire             out_ready, // read accept
  output wire [WIDTH-1:0] out_data   // head word
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wp_r;
  reg [AW-1:0]    rp_r;
  reg [AW:0]      cnt_r;
  wire            wr_en;
  wire            rd_en;
  assign in_ready  = (cnt_r != DEPTH[AW:0]);
  assign out_valid = (cnt_r != {(AW+1){1'b0}});
  assign out_data  = mem[rp_r];
  assign wr_en     = in_valid & in_ready & ~flush;
  assign rd_en     = out_valid & out_ready & ~flush;
  always @(posedge clk) begin
    if (wr_en) begin
      mem[wp_r] <= in_data;
    end
  end
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wp_r  <= {AW{1'b0}};
      rp_r  <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end else if (flush) begin
      wp_r  <= {AW{1'b0}};
      rp_r  <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end else begin
      if (wr_en) begin
        wp_r <= wp_r + 1'b1;
      end
      if (rd_en) begin
        rp_r <= rp_r + 1'b1;
      end
      if (wr_en & ~rd_en) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (rd_en & ~wr_en) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end
endmodule // stream_fifo
`default_nettype wire

/* verilog/serial_flash_cmd_front_end_read.v */
// Purpose: Serial command front end with continuous array reads and wide data lines.
// Assumes: clk far faster than the link clock; link pins sampled by two flip-flops.
// Notes:   Array bytes arrive from a memory port through an 8-word FIFO.
// What this block does
// - Chip select falling starts a command; 8-bit opcode then address on serial in.
// - Opcode, address and data move most significant bit first.
// - Three address bytes carry don't-care bits and real bits by page size.
// - Standard pages: 10-bit buffer index, 12 row bits plus 10 offset bits.
// - Binary pages: 9-bit buffer index, 21 flat bits, 12 page plus 9 byte.
// - Dual-input buffer write turns serial out into a second input.
// - Dual-output read drives serial in as line 0, serial out as line 1.
// - Quad transfers use reset, write protect, serial out, serial in as lines 3..0.
// - Quad use only after the quad enable command set the flag.
// - Legacy read: E8h, three address bytes, four dummy bytes, then data out.
// - Address counter advances by itself while clocks keep coming.
// - Page end continues at next page start with no gap.
// - Array end wraps to first page with no gap.
// - Chip select rising ends the read and floats serial out.
// - Array reads leave both buffers untouched.
// - Fast read: 1Bh, three address bytes, two dummy bytes, then data.
// - Output data changes on the falling link clock edge.
//
// ==========================================================================
// Timing overview
// The link pins pass two flip-flops, so every link clock edge acts about
// three system clocks after it appears on the pin. The host therefore must
// keep each link clock half period at least four system clocks long.
// Read data is prefetched into the FIFO while the dummy bits shift in.
// This hides the array's access time, so the first output group is ready
// at the first falling link clock edge after the last dummy bit.
// Only one array fetch is in flight at a time. The address registers move
// on the acknowledge, and the next request waits one cycle for them, so
// every request carries a fresh address and the FIFO can never overflow.
// The FIFO stays flushed while chip select is high, so a late acknowledge
// from a cut frame is dropped and never reaches the next frame's output.
// Buffer writes count bits per group of lines and raise one strobe a byte.
// The buffer index then steps by one, whatever the link clock does next.
// Limitation: no opcode besides those listed in the constants is decoded;
// any other opcode still takes three address bytes, then leaves the block idle until chip select rises again.
// ==========================================================================
`timescale 1ns/1ps
`default_nettype none
`include "flash_front_end_regs.vh"
module serial_flash_cmd_front_end_read #(
  parameter FIFO_DEPTH = 8,
  parameter FIFO_AW    = 3
) (
  input  wire        clk,           // 40 MHz system clock
  input  wire        resetn,        // async reset, active low
  input  wire        sck,           // link clock pin
  input  wire        cs_n,          // chip select pin, active low
  input  wire [3:0]  dq_in,         // quad_data_lines input levels
  output reg  [3:0]  dq_out,        // quad_data_lines drive values
  output reg  [3:0]  dq_oe,         // quad_data_lines enables, high drives
  input  wire        page_binary,   // 1 selects 512-byte pages
  output reg         mem_req,       // array fetch request
  output reg  [21:0] mem_addr,      // array byte address, page then offset
  input  wire        mem_ack,       // array byte valid this cycle
  input  wire [7:0]  mem_data,      // array byte
  output reg         buf_we,        // buffer byte write strobe
  output reg         buf_sel,       // buffer chosen by opcode
  output reg  [9:0]  buf_addr,      // buffer_byte_index
  output reg  [7:0]  buf_data,      // buffer write byte
  output reg         quad_enable_flag // quad lines permitted
);
  // ========================================================================
  // Link pin synchronisers
  reg [1:0] sck_s_r;
  reg [1:0] cs_s_r;
  reg [3:0] dq_s1_r;
  reg [3:0] dq_s2_r;
  reg       sck_d_r;
  reg       cs_d_r;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sck_s_r <= 2'h0;
      cs_s_r  <= 2'h3;
      dq_s1_r <= 4'h0;
      dq_s2_r <= 4'h0;
      sck_d_r <= 1'b0;
      cs_d_r  <= 1'b1;
    end else begin
      sck_s_r <= {sck_s_r[0], sck};
      cs_s_r  <= {cs_s_r[0], cs_n};
      dq_s1_r <= dq_in;
      dq_s2_r <= dq_s1_r;
      sck_d_r <= sck_s_r[1];
      cs_d_r  <= cs_s_r[1];
    end
  end
  wire cs_lo   = ~cs_s_r[1];
  wire cs_rise = cs_s_r[1] & ~cs_d_r;
  wire sck_up  = cs_lo & sck_s_r[1] & ~sck_d_r;
  wire sck_dn  = cs_lo & ~sck_s_r[1] & sck_d_r;
  // ========================================================================
  // Command sequencer
  localparam ST_OPC  = 3'h0;
  localparam ST_ADDR = 3'h1;
  localparam ST_DUMY = 3'h2;
  localparam ST_READ = 3'h3;
  localparam ST_WRIT = 3'h4;
  localparam ST_IDLE = 3'h5;
  reg [2:0]  state_r;
  reg [7:0]  opc_r;
  reg [23:0] sh_r;
  reg [5:0]  cnt_r;
  reg [1:0]  width_r;
  reg [7:0]  out_r;
  reg [3:0]  outbits_r;
  reg        primed_r;
  reg        pend_r;
  reg [11:0] row_r;
  reg [9:0]  ofs_r;
  // Bits per link clock for an opcode: 0 single, 1 dual, 2 quad.
  function [1:0] lane_code;
    input [7:0] op;
    input       qe;
    begin
      case (op)
        `OP_READ_DUAL, `OP_WRITE_DUAL: lane_code = 2'h1;
        `OP_READ_QUAD, `OP_WRITE_QUAD: lane_code = qe ? 2'h2 : 2'h0;
        default:                       lane_code = 2'h0;
      endcase
    end
  endfunction
  function [5:0] dummy_bits;
    input [7:0] op;
    begin
      case (op)
        `OP_READ_LEGACY: dummy_bits = 6'd32;
        `OP_READ_FAST:   dummy_bits = 6'd16;
        default:         dummy_bits = 6'd8;
      endcase
    end
  endfunction
  wire        is_read  = (opc_r == `OP_READ_LEGACY) | (opc_r == `OP_READ_FAST) |
                         (opc_r == `OP_READ_DUAL) | (opc_r == `OP_READ_QUAD);
  wire        is_write = (opc_r == `OP_WRITE_DUAL) | (opc_r == `OP_WRITE_QUAD);
  wire [7:0]  opc_nxt  = {sh_r[6:0], dq_s2_r[0]};
  wire [23:0] addr_nxt = {sh_r[22:0], dq_s2_r[0]};
  // Don't-care leading bits fall away in the slicing below.
  wire [11:0] row_dec  = page_binary ? addr_nxt[20:9] : addr_nxt[21:10];
  wire [9:0]  ofs_dec  = page_binary ? {1'b0, addr_nxt[8:0]} : addr_nxt[9:0];
  wire [9:0]  ofs_last = page_binary ? `PAGE_LAST_BIN : `PAGE_LAST_STD;
  wire [2:0]  lanes    = (width_r == 2'h2) ? 3'd4 : (width_r == 2'h1) ? 3'd2 : 3'd1;
  // ========================================================================
  // Read data prefetch FIFO
  wire       ff_in_ready;
  wire       ff_valid;
  wire [7:0] ff_data;
  wire       ff_take = (state_r == ST_READ) & ff_valid & (outbits_r == 4'h0) & ~primed_r;
  stream_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_fifo (
    .clk       (clk),
    .resetn    (resetn),
    .flush     (~cs_lo),
    .in_valid  (mem_ack),
    .in_ready  (ff_in_ready),
    .in_data   (mem_data),
    .out_valid (ff_valid),
    .out_ready (ff_take),
    .out_data  (ff_data)
  );
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_r          <= ST_IDLE;
      opc_r            <= 8'h00;
      sh_r             <= 24'h000000;
      cnt_r            <= 6'h00;
      width_r          <= 2'h0;
      out_r            <= 8'h00;
      outbits_r        <= 4'h0;
      primed_r         <= 1'b0;
      pend_r           <= 1'b0;
      row_r            <= 12'h000;
      ofs_r            <= 10'h000;
      dq_out           <= 4'h0;
      dq_oe            <= 4'h0;
      mem_req          <= 1'b0;
      mem_addr         <= 22'h000000;
      buf_we           <= 1'b0;
      buf_sel          <= 1'b0;
      buf_addr         <= 10'h000;
      buf_data         <= 8'h00;
      quad_enable_flag <= 1'b0;
    end else begin
      buf_we <= 1'b0;
      // The index steps once per stored byte, in the cycle after the strobe.
      if (buf_we) begin
        buf_addr <= buf_addr + 1'b1;
      end
      if (cs_rise | ~cs_lo) begin
        state_r   <= ST_OPC;
        cnt_r     <= 6'h00;
        dq_oe     <= 4'h0;
        mem_req   <= 1'b0;
        outbits_r <= 4'h0;
        primed_r  <= 1'b0;
        pend_r    <= 1'b0;
      end else begin
        // Fetches run ahead only while the FIFO has room; the sink stalls them.
        // A new request waits until the address has moved past the last answer.
        mem_req <= (state_r == ST_DUMY || state_r == ST_READ) & ff_in_ready & ~mem_req &
                   ~pend_r & ~mem_ack;
        if (mem_req) begin
          pend_r <= 1'b1;
        end else if (mem_ack) begin
          pend_r <= 1'b0;
        end
        if (mem_ack & ff_in_ready) begin
          if (ofs_r == ofs_last) begin
            ofs_r <= 10'h000;
            row_r <= (row_r == `PAGE_LAST_ROW) ? 12'h000 : row_r + 1'b1;
          end else begin
            ofs_r <= ofs_r + 1'b1;
          end
        end
        mem_addr <= page_binary ? {1'b0, row_r, ofs_r[8:0]} : {row_r, ofs_r};
        case (state_r)
          ST_OPC: if (sck_up) begin
            sh_r  <= {16'h0000, opc_nxt};
            cnt_r <= cnt_r + 1'b1;
            if (cnt_r == `OPCODE_BITS - 1) begin
              opc_r   <= opc_nxt;
              width_r <= lane_code(opc_nxt, quad_enable_flag);
              cnt_r   <= 6'h00;
              if (opc_nxt == `OP_QUAD_ENABLE) begin
                quad_enable_flag <= 1'b1;
                state_r <= ST_IDLE;
              end else begin
                state_r <= ST_ADDR;
              end
            end
          end
          ST_ADDR: if (sck_up) begin
            sh_r  <= addr_nxt;
            cnt_r <= cnt_r + 1'b1;
            if (cnt_r == `ADDR_BITS - 1) begin
              cnt_r    <= 6'h00;
              row_r    <= row_dec;
              ofs_r    <= ofs_dec;
              buf_addr <= page_binary ? {1'b0, addr_nxt[8:0]} : addr_nxt[9:0];
              buf_sel  <= opc_r[0];
              state_r  <= is_write ? ST_WRIT : is_read ? ST_DUMY : ST_IDLE;
            end
          end
          ST_DUMY: if (sck_up) begin
            cnt_r <= cnt_r + 1'b1;
            if (cnt_r == dummy_bits(opc_r) - 1'b1) begin
              state_r <= ST_READ;
            end
          end
          ST_READ: begin
            // Array reads never touch buf_we, leaving the buffers intact.
            if (ff_take) begin
              out_r     <= ff_data;
              outbits_r <= 4'h8;
              primed_r  <= 1'b1;
            end
            if (sck_dn && outbits_r != 4'h0) begin
              dq_oe <= (width_r == 2'h2) ? 4'hF :
                       (width_r == 2'h1) ? 4'h3 : 4'h2;
              case (width_r)
                2'h2:    dq_out <= out_r[7:4];
                2'h1:    dq_out <= {2'b00, out_r[7:6]};
                default: dq_out <= {2'b00, out_r[7], 1'b0};
              endcase
              out_r     <= out_r << lanes;
              outbits_r <= outbits_r - {1'b0, lanes};
              primed_r  <= 1'b0;
            end
          end
          ST_WRIT: if (sck_up) begin
            dq_oe <= 4'h0;
            sh_r  <= (width_r == 2'h2) ? {sh_r[19:0], dq_s2_r} :
                     (width_r == 2'h1) ? {sh_r[21:0], dq_s2_r[1:0]} :
                                         {sh_r[22:0], dq_s2_r[0]};
            cnt_r <= cnt_r + {3'b000, lanes};
            if (cnt_r + {3'b000, lanes} == 6'd8) begin
              cnt_r    <= 6'h00;
              buf_we   <= 1'b1;
              buf_data <= (width_r == 2'h2) ? {sh_r[3:0], dq_s2_r} :
                          (width_r == 2'h1) ? {sh_r[5:0], dq_s2_r[1:0]} :
                                              {sh_r[6:0], dq_s2_r[0]};
            end
          end
          default: state_r <= ST_IDLE;
        endcase
      end
    end
  end
endmodule // serial_flash_cmd_front_end_read
`default_nettype wire

/* dv/front_end_checker_assertions.sv */
// Purpose: Port-level checks of the serial flash command front end.
// Assumes: Sees only the top module's ports.
// Notes:   The address follower forgets its history whenever chip select is high.
`timescale 1ns/1ps
`default_nettype none
module front_end_checker #(
  parameter int FIFO_DEPTH = 8,
  parameter int FIFO_AW    = 3
) (
  input wire logic        clk,              // system clock
  input wire logic        resetn,           // async reset, active low
  input wire logic        cs_n,             // chip select pin
  input wire logic [3:0]  dq_oe,            // data line enables
  input wire logic        page_binary,      // page size select
  input wire logic        mem_req,          // array fetch request
  input wire logic [21:0] mem_addr,         // array byte address
  input wire logic        buf_we,           // buffer write strobe
  input wire logic        quad_enable_flag  // quad lines permitted
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  logic        pv_r;
  logic [21:0] pa_r;
  // ==========================================================================
  // Address follower
  function automatic logic [21:0] nx(input logic pb, input logic [21:0] a);
    if (pb) return {1'b0, a[20:0] + 21'h1};
    if (a[9:0] == 10'h20F) return {a[21:10] + 12'h1, 10'h0};
    return a + 22'h1;
  endfunction
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pv_r <= 1'b0;
      pa_r <= 22'h0;
    end else begin
      pv_r <= !cs_n && (pv_r || mem_req);
      pa_r <= mem_req ? mem_addr : pa_r;
    end
  end
  // ==========================================================================
  // Properties
  sequence s_cs_rise; $rose(cs_n); endsequence
  sequence s_float; (dq_oe == 4'h0) [*2]; endsequence
  a_cs_rise_float: assert property (s_cs_rise |-> ##[1:6] s_float)
    else $error("lines still driven after chip select rose");
  a_next_addr: assert property (mem_req && pv_r |-> mem_addr == nx(page_binary, pa_r))
    else $error("fetch address did not follow the previous one");
  a_addr_range: assert property (mem_req |-> (page_binary ? !mem_addr[21] : mem_addr[9:0] <= 10'h20F))
    else $error("fetch address outside the page layout");
  a_quad_gate: assert property (|dq_oe[3:2] |-> quad_enable_flag)
    else $error("upper lines driven without quad permission");
  a_line_pairs: assert property (dq_oe[2] == dq_oe[3] && (!dq_oe[0] || dq_oe[1]))
    else $error("data line enables out of step");
  a_flag_sticky: assert property (quad_enable_flag |=> quad_enable_flag)
    else $error("quad permission dropped without reset");
  a_fetch_no_write: assert property (mem_req |-> !buf_we)
    else $error("buffer written during an array fetch");
  a_we_pulse: assert property (buf_we |=> !buf_we)
    else $error("buffer write strobe longer than one cycle");
  a_reset_quiet: assert property ($rose(resetn) |-> dq_oe == 4'h0 && !mem_req && !quad_enable_flag)
    else $error("outputs active right after reset");
endmodule // front_end_checker
bind serial_flash_cmd_front_end_read front_end_checker #(.FIFO_DEPTH(FIFO_DEPTH), .FIFO_AW(FIFO_AW))
  u_chk (.clk(clk), .resetn(resetn), .cs_n(cs_n), .dq_oe(dq_oe), .page_binary(page_binary),
         .mem_req(mem_req), .mem_addr(mem_addr), .buf_we(buf_we),
         .quad_enable_flag(quad_enable_flag));
`default_nettype wire

/* dv/spi_host_model.sv */
// Purpose: Serial link controller that issues commands to the front end.
// Assumes: Mode 0 link clock, idle low, moved only inside a frame.
// Notes:   Samples the lines just before each rising link clock edge.
`timescale 1ns/1ps
`default_nettype none
module spi_host_model #(
  parameter int HALF = 4
) (
  input  wire logic       clk,   // system clock
  input  wire logic [3:0] line,  // resolved data line levels
  output var  logic       cs_n,  // chip select, active low
  output var  logic       sck,   // link clock
  output var  logic [3:0] h_out, // host drive values
  output var  logic [3:0] h_oe   // host drive enables
);
  logic [7:0] rxq[$];
  initial begin
    cs_n  = 1'b1;
    sck   = 1'b0;
    h_out = 4'h0;
    h_oe  = 4'h0;
  end
  task automatic shift(input logic [7:0] tx, input int w, input bit drv, output logic [7:0] rx);
    logic [3:0] m;
    m  = (w == 4) ? 4'hF : (w == 2) ? 4'h3 : 4'h1;
    rx = 8'h00;
    for (int i = 8 - w; i >= 0; i -= w) begin
      h_out <= 4'(tx >> i) & m;
      h_oe  <= drv ? m : 4'h0;
      repeat (HALF) @(posedge clk);
      rx = (rx << w) | 8'((w == 1) ? {3'b000, line[1]} : line & m);
      sck <= 1'b1;
      repeat (HALF) @(posedge clk);
      sck <= 1'b0;
    end
  endtask
  // Chip select stays low from opcode to last data group.
  task automatic cmd(input logic [7:0] op, input logic [23:0] a, input int nd, input int w,
                     input int nb, input bit wr, input logic [7:0] wd);
    logic [7:0] r;
    rxq.delete();
    @(posedge clk);
    cs_n <= 1'b0;
    shift(op, 1, 1'b1, r);
    if (op != 8'h3D) for (int k = 2; k >= 0; k--) shift(a[8*k+:8], 1, 1'b1, r);
    repeat (nd) shift(8'h00, 1, 1'b1, r);
    repeat (nb) begin
      shift(wd, w, wr, r);
      rxq.push_back(r);
      wd = wd + 8'h01;
    end
    repeat (HALF) @(posedge clk);
    cs_n <= 1'b1;
    h_oe <= 4'h0;
    repeat (8) @(posedge clk);
  endtask
endmodule // spi_host_model
`default_nettype wire

/* dv/serial_flash_cmd_front_end_read_bench.sv */
// Purpose: Self-checking bench of the serial flash command front end.
// Assumes: Array bytes come back two cycles after each fetch request.
// Notes:   Link clock period is 200 ns so each half period spans four system clocks.
`timescale 1ns/1ps
`default_nettype none
module serial_flash_cmd_front_end_read_bench;
  typedef struct {logic [7:0] op; logic pb; logic [23:0] a; int nd; int w; int nb;} row_t;
  logic        clk = 1'b0, resetn = 1'b0, page_binary = 1'b0, mem_ack = 1'b0, p1 = 1'b0;
  logic [7:0]  mem_data = 8'h00;
  logic [21:0] a1 = 22'h0;
  logic [1:0]  fl = 2'h0;
  logic        sck, cs_n, mem_req, buf_we, buf_sel, quad_enable_flag;
  logic [3:0]  dq_out, dq_oe, dq_in, h_out, h_oe;
  logic [21:0] mem_addr;
  logic [9:0]  buf_addr;
  logic [7:0]  buf_data;
  logic [18:0] bufq[$];
  int          fails = 0, checks_done = 0;
  // Quad read before permission must fall back to one line.
  row_t rows[8] = '{'{8'hE8, 0, 24'h00160E, 4, 1, 3}, '{8'h1B, 1, 24'hFFFFFF, 2, 1, 2},
                    '{8'h1B, 0, 24'hFFFE0F, 2, 1, 2}, '{8'hE8, 1, 24'h0003FE, 4, 1, 3},
                    '{8'h6B, 0, 24'h000030, 1, 1, 2}, '{8'h3D, 0, 24'h000000, 0, 1, 0},
                    '{8'h3B, 0, 24'h00020E, 1, 2, 3}, '{8'h6B, 1, 24'h1FFFFE, 1, 4, 3}};
  always #12.5 clk = ~clk;
  // Undriven serial lines toggle so a stale level never passes; the upper two are pulled up.
  assign dq_in = (dq_oe & dq_out) | (~dq_oe & h_oe & h_out) | (~dq_oe & ~h_oe & {2'b11, fl});
  serial_flash_cmd_front_end_read #(.FIFO_DEPTH(8), .FIFO_AW(3)) u_dut (
    .clk(clk), .resetn(resetn), .sck(sck), .cs_n(cs_n), .dq_in(dq_in), .dq_out(dq_out),
    .dq_oe(dq_oe), .page_binary(page_binary), .mem_req(mem_req), .mem_addr(mem_addr),
    .mem_ack(mem_ack), .mem_data(mem_data), .buf_we(buf_we), .buf_sel(buf_sel),
    .buf_addr(buf_addr), .buf_data(buf_data), .quad_enable_flag(quad_enable_flag));
  spi_host_model #(.HALF(4)) u_host (.clk(clk), .line(dq_in), .cs_n(cs_n), .sck(sck),
    .h_out(h_out), .h_oe(h_oe));
  // ==========================================================================
  // Array memory and write monitor
  function automatic logic [7:0] m8(input logic [21:0] a);
    return a[7:0] ^ a[19:12];
  endfunction
  function automatic logic [21:0] nx(input logic pb, input logic [21:0] a);
    if (pb) return {1'b0, a[20:0] + 21'h1};
    if (a[9:0] == 10'h20F) return {a[21:10] + 12'h1, 10'h0};
    return a + 22'h1;
  endfunction
  always @(posedge clk) begin
    p1       <= mem_req;
    a1       <= mem_addr;
    mem_ack  <= p1;
    mem_data <= m8(a1);
    fl       <= fl + 2'h1;
    if (buf_we === 1'b1) bufq.push_back({buf_sel, buf_addr, buf_data});
  end
  // ==========================================================================
  // Checking tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic run(input row_t r);
    logic [21:0] a;
    @(posedge clk);
    page_binary <= r.pb;
    u_host.cmd(r.op, r.a, r.nd, r.w, r.nb, 1'b0, 8'h00);
    a = r.pb ? {1'b0, r.a[20:0]} : r.a[21:0];
    check(u_host.rxq.size(), r.nb);
    foreach (u_host.rxq[i]) begin
      check(u_host.rxq[i], m8(a));
      a = nx(r.pb, a);
    end
    check(dq_oe, 32'h0);
  endtask
  task automatic wr(input logic [7:0] op, input int w, input logic [9:0] ix);
    bufq.delete();
    @(posedge clk);
    page_binary <= 1'b0;
    u_host.cmd(op, {14'h0, ix}, 0, w, 2, 1'b1, 8'hA5);
    check(bufq.size(), 2);
    for (int k = 0; k < 2; k++) check(bufq[k], {op[0], 10'(ix + k), 8'(8'hA5 + k)});
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ==========================================================================
  // Main sequence
  initial begin
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    foreach (rows[i]) run(rows[i]);
    check(bufq.size(), 0);
    check(quad_enable_flag, 1);
    wr(8'h24, 2, 10'h20E);
    wr(8'h44, 4, 10'h1FF);
    @(posedge clk);
    resetn <= 1'b0;
    repeat (3) @(posedge clk);
    check({quad_enable_flag, dq_oe}, 32'h0);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    run('{8'h6B, 0, 24'h3FFC10, 1, 1, 1});
    end_of_test();
  end
  initial begin
    repeat (60000) @(posedge clk);
    fails++;
    end_of_test();
  end
endmodule // serial_flash_cmd_front_end_read_bench
`default_nettype wire
